//--- shared/adcc_cfg.svh
// offsets, field positions, reset values and counts of the converter control
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// =============================================================
// register byte offsets
`define ADCC_OFF_CONVERSION_CONTROL_B 8'h04
`define ADCC_OFF_WINDOW_CONTROL 8'h08
`define ADCC_OFF_SOFTWARE_TRIGGER 8'h0C
`define ADCC_OFF_INCTRL 8'h10
`define ADCC_OFF_EVCTRL 8'h14
`define ADCC_OFF_RESULT 8'h18
`define ADCC_OFF_WINDOW_LOWER_THRESHOLD 8'h1C
`define ADCC_OFF_WINDOW_UPPER_THRESHOLD 8'h20
`define ADCC_OFF_GAIN_CALIBRATION 8'h24
`define ADCC_OFF_OFFCAL 8'h28
`define ADCC_OFF_STATUS 8'h2C

// =============================================================
// writable bit masks
`define ADCC_CONVERSION_CONTROL_B_MASK 16'h073F
`define ADCC_INCTRL_MASK 32'h0FFF1F1F

// =============================================================
// field positions
`define ADCC_B_DIFF 0
`define ADCC_B_LEFT 1
`define ADCC_B_FREE 2
`define ADCC_B_CORR 3
`define ADCC_B_FLUSH 0
`define ADCC_B_START 1
`define ADCC_B_WINEO 5
`define ADCC_F_PRESC 10:8
`define ADCC_F_POSITIVE_INPUT_SELECT 4:0
`define ADCC_F_NEGATIVE_INPUT_SELECT 12:8
`define ADCC_F_SCAN 19:16
`define ADCC_F_OFFSET 23:20
`define ADCC_F_GAIN 27:24

// =============================================================
// reset values and codes
`define ADCC_RST_CONVERSION_CONTROL_B 16'h0000
`define ADCC_RST_INCTRL 32'h00000000
`define ADCC_RST_GAIN_CALIBRATION 12'h800
`define ADCC_RST_OFFCAL 12'h000
`define ADCC_NEG_GND 5'h18
`define ADCC_NEG_IOGND 5'h19
`define ADCC_POS_BANDGAP 5'h19
`define ADCC_POS_CORE_Q 5'h1A
`define ADCC_POS_IO_Q 5'h1B

// =============================================================
// timing counts: conversion length in converter clock ticks, divider base in bus clock cycles
`define ADCC_CONV_TICKS 8'h0D
`define ADCC_DIV_BASE 10'h004

`endif

//--- shared/adcc_pkg.sv
// types of the converter control block
package adcc_pkg;
  // =============================================================
  // conversion engine states
  typedef enum logic {ADCC_IDLE, ADCC_CONV} adcc_state_t;
endpackage : adcc_pkg

//--- design/adcc_result_proc.sv
// gain and offset correction and alignment of one conversion result
`timescale 1ns/10ps
`include "adcc_cfg.svh"

module adcc_result_proc (
  input wire logic [11:0] raw,
  input wire logic corr_en,
  input wire logic left_align,
  input wire logic [11:0] gain_cal,
  input wire logic [11:0] off_cal,
  output logic [15:0] result
);
  // =============================================================
  // correction datapath
  logic signed [12:0] dif; // raw minus offset
  logic signed [25:0] prod; // times gain, gain is 1.11 fixed point
  logic signed [14:0] scl; // product back to integer scale
  logic [11:0] val; // clamped value

  // gain 12'h800 is unity; clamp instead of wrapping on overflow
  always_comb begin
    dif = $signed({1'b0, raw}) - $signed({1'b0, off_cal});
    prod = dif * $signed({1'b0, gain_cal});
    scl = prod[25:11];
    if (!corr_en) begin
      val = raw; // correction off: raw passes [RQ1]
    end else if (scl < 15'sh0000) begin
      val = 12'h000;
    end else if (scl > 15'sh0FFF) begin
      val = 12'hFFF;
    end else begin
      val = scl[11:0]; // corrected value [RQ1]
    end
    result = left_align ? {val, 4'h0} : {4'h0, val}; // [RQ4]
  end
endmodule : adcc_result_proc

//--- design/adcc_window_cmp.sv
// window monitor comparison of a result against two thresholds
`timescale 1ns/10ps
`include "adcc_cfg.svh"

module adcc_window_cmp (
  input wire logic [2:0] mode,
  input wire logic [15:0] res,
  input wire logic [15:0] lower,
  input wire logic [15:0] upper,
  output logic hit
);
  // =============================================================
  // comparison
  logic above; // result over lower threshold
  logic below; // result under upper threshold

  // strict compares on both sides, equal values never flag inside
  always_comb begin
    above = res > lower;
    below = res < upper;
    case (mode)
      3'h1: hit = above; // [RQ6]
      3'h2: hit = below; // [RQ6]
      3'h3: hit = above & below; // [RQ6]
      3'h4: hit = !(above & below); // [RQ6]
      default: hit = 1'b0; // off and reserved codes [RQ27]
    endcase
  end
endmodule : adcc_window_cmp

//--- design/adcc_top.sv
// apb register file and conversion sequencing of the converter control
// Operation
// (RQ1) correction applies gain and offset calibration
// (RQ2) correction lengthens conversion by offset value
// (RQ3) single conversion per trigger, or free running
// (RQ4) left align puts result high
// (RQ5) differential converts positive minus negative
// (RQ6) window mode selects one of four comparisons
// (RQ7) software avoids reserved window and gain codes
// (RQ8) start bit begins conversion, clears on start
// (RQ9) start while set queues nothing more
// (RQ10) writing zero to start or flush: nothing
// (RQ11) flush aborts conversions, restarts converter clock
// (RQ12) flush bit clears itself when done
// (RQ13) after flush, a pending request still starts
// (RQ14) gain field selects stage factor
// (RQ15) positive input is selection plus scan position
// (RQ16) scan position advances after each conversion
// (RQ17) scan covers scan count plus one inputs
// (RQ18) software keeps scan range within inputs
// (RQ19) negative select codes: pins and grounds
// (RQ20) positive select codes map to pins
// (RQ21) software sets sampling time for internal inputs
// (RQ22) window, trigger, input registers write synchronized
// (RQ23) sync pending flag while write not applied
// (RQ24) positive codes for bandgap and scaled supplies
// (RQ25) window detection emits event when enabled
// (RQ26) scan position wraps to zero past count
// (RQ27) reserved window codes detect nothing
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "adcc_cfg.svh"

module adcc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] adc_raw,
  output logic adc_start,
  output logic [4:0] adc_pos_sel,
  output logic [4:0] adc_neg_sel,
  output logic adc_diff,
  output logic [3:0] adc_gain,
  output logic result_ready,
  output logic window_event
);
  // =============================================================
  // state
  logic [15:0] conversion_control_b_q, conversion_control_b_d; // conversion_control_b
  logic [2:0] win_sh_q, win_sh_d; // window_control as written
  logic [2:0] win_act_q, win_act_d; // window_control in effect
  logic [31:0] in_sh_q, in_sh_d; // input_control as written
  logic [31:0] in_act_q, in_act_d; // input_control in effect
  logic evo_q, evo_d; // window_event_output_enable
  logic [15:0] window_lower_threshold_q, window_lower_threshold_d; // window_lower_threshold
  logic [15:0] window_upper_threshold_q, window_upper_threshold_d; // window_upper_threshold
  logic [11:0] gcal_q, gcal_d; // gain_calibration
  logic [11:0] ocal_q, ocal_d; // offset_calibration
  logic [15:0] res_q, res_d; // last result
  logic start_q, start_d; // software start bit
  logic flush_q, flush_d; // flush bit
  logic pend_wc_q, pend_wc_d; // window write not yet applied
  logic pend_sw_q, pend_sw_d; // trigger write not yet applied
  logic pend_ic_q, pend_ic_d; // input write not yet applied
  logic run_q, run_d; // free running sequence active
  adcc_pkg::adcc_state_t state_q, state_d; // engine state
  logic [8:0] div_q, div_d; // converter clock prescaler
  logic [7:0] cnt_q, cnt_d; // ticks into the conversion
  logic start_o_q, start_o_d; // start pulse to the analog core
  logic [4:0] pos_q, pos_d; // latched positive select
  logic [4:0] neg_q, neg_d; // latched negative select
  logic diff_q, diff_d; // latched differential mode
  logic [3:0] gain_q, gain_d; // latched gain code
  logic rdy_q, rdy_d; // result ready pulse
  logic wev_q, wev_d; // window event pulse
  logic [31:0] rd_q, rd_d; // read data

  // =============================================================
  // decode and derived terms
  logic wr; // write taken this cycle
  logic sel_ok; // address maps to a register
  logic [9:0] div_max; // prescaler terminal count
  logic tick; // one converter clock period ends
  logic [7:0] conv_len; // ticks per conversion
  logic start_go; // conversion begins this cycle
  logic done; // conversion completes this cycle
  logic [15:0] proc_res; // corrected and aligned result
  logic win_hit; // window condition on that result
  logic [3:0] scan_pos; // scan position in effect
  logic [3:0] scan_cnt; // scan count in effect

  assign wr = psel & penable & pwrite;
  assign div_max = (`ADCC_DIV_BASE << conversion_control_b_q[`ADCC_F_PRESC]) - 10'h001;
  assign tick = div_q == div_max[8:0];
  // with correction on, each conversion takes extra ticks set by the low four offset bits [RQ2]
  assign conv_len = `ADCC_CONV_TICKS + (conversion_control_b_q[`ADCC_B_CORR] ?
                    {4'h0, ocal_q[3:0]} : 8'h00);
  // trigger or free run starts only when idle; flush holds it off
  assign start_go = (state_q == adcc_pkg::ADCC_IDLE) & tick & !flush_q &
                    (start_q | run_q); // [RQ3] [RQ13]
  assign done = (state_q == adcc_pkg::ADCC_CONV) & tick & !flush_q &
                (cnt_q == conv_len - 8'h01);
  assign scan_pos = in_act_q[`ADCC_F_OFFSET];
  assign scan_cnt = in_act_q[`ADCC_F_SCAN];

  // apb: no wait states, unmapped addresses answer with an error
  always_comb begin
    unique case (paddr)
      `ADCC_OFF_CONVERSION_CONTROL_B, `ADCC_OFF_WINDOW_CONTROL, `ADCC_OFF_SOFTWARE_TRIGGER,
      `ADCC_OFF_INCTRL, `ADCC_OFF_EVCTRL, `ADCC_OFF_RESULT,
      `ADCC_OFF_WINDOW_LOWER_THRESHOLD, `ADCC_OFF_WINDOW_UPPER_THRESHOLD, `ADCC_OFF_GAIN_CALIBRATION,
      `ADCC_OFF_OFFCAL, `ADCC_OFF_STATUS: sel_ok = 1'b1;
      default: sel_ok = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & !sel_ok;
  assign prdata = rd_q;

  // =============================================================
  // result processing and window compare
  adcc_result_proc u_proc (
    .raw(adc_raw),
    .corr_en(conversion_control_b_q[`ADCC_B_CORR]),
    .left_align(conversion_control_b_q[`ADCC_B_LEFT]),
    .gain_cal(gcal_q),
    .off_cal(ocal_q),
    .result(proc_res)
  );

  adcc_window_cmp u_win (
    .mode(win_act_q),
    .res(proc_res),
    .lower(window_lower_threshold_q),
    .upper(window_upper_threshold_q),
    .hit(win_hit)
  );

  // =============================================================
  // register file next state
  // synchronized registers read back at once but act at the next tick
  always_comb begin
    conversion_control_b_d = conversion_control_b_q;
    win_sh_d = win_sh_q;
    win_act_d = win_act_q;
    in_sh_d = in_sh_q;
    in_act_d = in_act_q;
    evo_d = evo_q;
    window_lower_threshold_d = window_lower_threshold_q;
    window_upper_threshold_d = window_upper_threshold_q;
    gcal_d = gcal_q;
    ocal_d = ocal_q;
    pend_wc_d = pend_wc_q;
    pend_sw_d = pend_sw_q;
    pend_ic_d = pend_ic_q;
    start_d = start_q;
    flush_d = 1'b0; // flush lasts one cycle, then clears [RQ12]
    // the converter domain takes pending writes at its tick
    if (tick) begin
      if (pend_wc_q) begin
        win_act_d = win_sh_q; // [RQ22]
      end
      if (pend_ic_q) begin
        in_act_d = in_sh_q; // [RQ22]
      end
      pend_wc_d = 1'b0; // [RQ23]
      pend_sw_d = 1'b0; // [RQ23]
      pend_ic_d = 1'b0; // [RQ23]
    end
    // start bit clears once the conversion has begun [RQ8]
    if (start_go) begin
      start_d = 1'b0;
    end
    // scan position advances, wrapping past the count [RQ16] [RQ26]
    if (done) begin
      if (scan_pos >= scan_cnt) begin
        in_act_d[`ADCC_F_OFFSET] = 4'h0; // [RQ17] [RQ26]
      end else begin
        in_act_d[`ADCC_F_OFFSET] = scan_pos + 4'h1; // [RQ16]
      end
      // keep the read-back in step unless software is rewriting it
      if (!pend_ic_q) begin
        in_sh_d[`ADCC_F_OFFSET] = in_act_d[`ADCC_F_OFFSET];
      end
    end
    // software writes; a set that meets a clear wins
    if (wr) begin
      unique case (paddr)
        `ADCC_OFF_CONVERSION_CONTROL_B: conversion_control_b_d = pwdata[15:0] & `ADCC_CONVERSION_CONTROL_B_MASK;
        `ADCC_OFF_WINDOW_CONTROL: begin
          win_sh_d = pwdata[2:0];
          pend_wc_d = 1'b1; // [RQ23]
        end
        `ADCC_OFF_SOFTWARE_TRIGGER: begin
          pend_sw_d = 1'b1; // [RQ23]
          // zeros are ignored, a set bit only ever sets [RQ9] [RQ10]
          if (pwdata[`ADCC_B_START]) begin
            start_d = 1'b1; // [RQ8]
          end
          if (pwdata[`ADCC_B_FLUSH]) begin
            flush_d = 1'b1; // [RQ11]
          end
        end
        `ADCC_OFF_INCTRL: begin
          in_sh_d = pwdata & `ADCC_INCTRL_MASK;
          pend_ic_d = 1'b1; // [RQ23]
        end
        `ADCC_OFF_EVCTRL: evo_d = pwdata[`ADCC_B_WINEO];
        `ADCC_OFF_WINDOW_LOWER_THRESHOLD: window_lower_threshold_d = pwdata[15:0];
        `ADCC_OFF_WINDOW_UPPER_THRESHOLD: window_upper_threshold_d = pwdata[15:0];
        `ADCC_OFF_GAIN_CALIBRATION: gcal_d = pwdata[11:0];
        `ADCC_OFF_OFFCAL: ocal_d = pwdata[11:0];
        default: begin
          // result, status and unmapped addresses take no write
        end
      endcase
    end
  end

  // =============================================================
  // read data, captured in the setup cycle
  always_comb begin
    rd_d = rd_q;
    if (psel & !penable) begin
      unique case (paddr)
        `ADCC_OFF_CONVERSION_CONTROL_B: rd_d = {16'h0000, conversion_control_b_q};
        `ADCC_OFF_WINDOW_CONTROL: rd_d = {29'h00000000, win_sh_q};
        `ADCC_OFF_SOFTWARE_TRIGGER: rd_d = {30'h00000000, start_q, flush_q};
        `ADCC_OFF_INCTRL: rd_d = in_sh_q;
        `ADCC_OFF_EVCTRL: rd_d = {26'h0000000, evo_q, 5'h00};
        `ADCC_OFF_RESULT: rd_d = {16'h0000, res_q};
        `ADCC_OFF_WINDOW_LOWER_THRESHOLD: rd_d = {16'h0000, window_lower_threshold_q};
        `ADCC_OFF_WINDOW_UPPER_THRESHOLD: rd_d = {16'h0000, window_upper_threshold_q};
        `ADCC_OFF_GAIN_CALIBRATION: rd_d = {20'h00000, gcal_q};
        `ADCC_OFF_OFFCAL: rd_d = {20'h00000, ocal_q};
        // bit 0 sync pending, bit 1 conversion in progress
        `ADCC_OFF_STATUS: rd_d = {30'h00000000,
                                  state_q == adcc_pkg::ADCC_CONV,
                                  pend_wc_q | pend_sw_q | pend_ic_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // =============================================================
  // conversion engine next state
  always_comb begin
    state_d = state_q;
    div_d = tick ? 9'h000 : div_q + 9'h001;
    cnt_d = cnt_q;
    run_d = run_q & conversion_control_b_q[`ADCC_B_FREE]; // free run stops at once
    start_o_d = 1'b0;
    pos_d = pos_q;
    neg_d = neg_q;
    diff_d = diff_q;
    gain_d = gain_q;
    rdy_d = 1'b0;
    wev_d = 1'b0;
    res_d = res_q;
    if (flush_q) begin
      // abort, drop the result, restart the converter clock [RQ11]
      state_d = adcc_pkg::ADCC_IDLE;
      div_d = 9'h000;
      cnt_d = 8'h00;
    end else if (start_go) begin
      state_d = adcc_pkg::ADCC_CONV;
      cnt_d = 8'h00;
      start_o_d = 1'b1; // [RQ8]
      run_d = conversion_control_b_q[`ADCC_B_FREE]; // [RQ3]
      // selects come from the value in effect after this tick, so an
      // input write synchronized at the same tick as the trigger counts
      // positive input is selection plus scan position [RQ15]
      pos_d = in_act_d[`ADCC_F_POSITIVE_INPUT_SELECT] +
              {1'b0, in_act_d[`ADCC_F_OFFSET]}; // [RQ20] [RQ24]
      diff_d = conversion_control_b_q[`ADCC_B_DIFF]; // [RQ5]
      // single ended ties the negative side to internal ground
      neg_d = conversion_control_b_q[`ADCC_B_DIFF] ? in_act_d[`ADCC_F_NEGATIVE_INPUT_SELECT] :
              `ADCC_NEG_GND; // [RQ5] [RQ19]
      gain_d = in_act_d[`ADCC_F_GAIN]; // [RQ14]
    end else if (done) begin
      state_d = adcc_pkg::ADCC_IDLE;
      res_d = proc_res; // [RQ1] [RQ4]
      rdy_d = 1'b1;
      wev_d = win_hit & evo_q; // [RQ25]
    end else if (state_q == adcc_pkg::ADCC_CONV && tick) begin
      cnt_d = cnt_q + 8'h01; // [RQ2]
    end
  end

  // =============================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_control_b_q <= `ADCC_RST_CONVERSION_CONTROL_B;
      win_sh_q <= 3'h0;
      win_act_q <= 3'h0;
      in_sh_q <= `ADCC_RST_INCTRL;
      in_act_q <= `ADCC_RST_INCTRL;
      evo_q <= 1'b0;
      window_lower_threshold_q <= 16'h0000;
      window_upper_threshold_q <= 16'h0000;
      gcal_q <= `ADCC_RST_GAIN_CALIBRATION;
      ocal_q <= `ADCC_RST_OFFCAL;
      res_q <= 16'h0000;
      start_q <= 1'b0;
      flush_q <= 1'b0;
      pend_wc_q <= 1'b0;
      pend_sw_q <= 1'b0;
      pend_ic_q <= 1'b0;
      run_q <= 1'b0;
      state_q <= adcc_pkg::ADCC_IDLE;
      div_q <= 9'h000;
      cnt_q <= 8'h00;
      start_o_q <= 1'b0;
      pos_q <= 5'h00;
      neg_q <= 5'h00;
      diff_q <= 1'b0;
      gain_q <= 4'h0;
      rdy_q <= 1'b0;
      wev_q <= 1'b0;
      rd_q <= 32'h00000000;
    end else begin
      conversion_control_b_q <= conversion_control_b_d;
      win_sh_q <= win_sh_d;
      win_act_q <= win_act_d;
      in_sh_q <= in_sh_d;
      in_act_q <= in_act_d;
      evo_q <= evo_d;
      window_lower_threshold_q <= window_lower_threshold_d;
      window_upper_threshold_q <= window_upper_threshold_d;
      gcal_q <= gcal_d;
      ocal_q <= ocal_d;
      res_q <= res_d;
      start_q <= start_d;
      flush_q <= flush_d;
      pend_wc_q <= pend_wc_d;
      pend_sw_q <= pend_sw_d;
      pend_ic_q <= pend_ic_d;
      run_q <= run_d;
      state_q <= state_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      start_o_q <= start_o_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
      diff_q <= diff_d;
      gain_q <= gain_d;
      rdy_q <= rdy_d;
      wev_q <= wev_d;
      rd_q <= rd_d;
    end
  end

  assign adc_start = start_o_q;
  assign adc_pos_sel = pos_q;
  assign adc_neg_sel = neg_q;
  assign adc_diff = diff_q;
  assign adc_gain = gain_q;
  assign result_ready = rdy_q;
  assign window_event = wev_q;

  // =============================================================
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_start_begins: assert property (start_go |=> // [RQ8]
    state_q == adcc_pkg::ADCC_CONV && adc_start)
    else $error("start did not begin a conversion");
  chk_flush_abort: assert property (flush_q |=> // [RQ11]
    state_q == adcc_pkg::ADCC_IDLE && div_q == 9'h000 && !result_ready)
    else $error("flush did not abort");
  chk_flush_clear: assert property (flush_q && !wr |=> !flush_q) // [RQ12]
    else $error("flush bit stuck");
  chk_zero_write: assert property (wr && paddr == `ADCC_OFF_SOFTWARE_TRIGGER && // [RQ10]
    pwdata[1:0] == 2'h0 && !start_q && !flush_q |=> !start_q && !flush_q)
    else $error("zero write to trigger had an effect");
  chk_left_align: assert property (done && conversion_control_b_q[`ADCC_B_LEFT] |=> // [RQ4]
    result_ready && res_q[3:0] == 4'h0 && res_q[15:4] == $past(proc_res[15:4]))
    else $error("left aligned result wrong");
  chk_window_event: assert property (done && win_hit && evo_q |=> // [RQ25]
    window_event ##1 !window_event)
    else $error("window event missing");
  chk_scan_wrap: assert property (done && scan_pos >= scan_cnt |=> // [RQ26]
    in_act_q[`ADCC_F_OFFSET] == 4'h0)
    else $error("scan position did not wrap");
  chk_sync_apply: assert property (pend_ic_q && tick |=> // [RQ22]
    in_act_q[`ADCC_F_POSITIVE_INPUT_SELECT] == $past(in_sh_q[`ADCC_F_POSITIVE_INPUT_SELECT]))
    else $error("synchronized write not applied");
  chk_sync_flag: assert property (wr && paddr == `ADCC_OFF_WINDOW_CONTROL |=> // [RQ23]
    pend_wc_q)
    else $error("sync pending not raised");
  chk_single_shot: assert property (done && !conversion_control_b_q[`ADCC_B_FREE] && // [RQ3]
    !start_q && !wr |=> state_q == adcc_pkg::ADCC_IDLE [*2])
    else $error("single mode restarted on its own");
endmodule : adcc_top

//--- verification/adcc_tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/10ps
`include "adcc_cfg.svh"

module adc_conversion_control_tb_top;
  // =============================================================
  // signals
  logic pclk = 1'b0; // bus clock, 5 ns
  logic presetn = 1'b0; // held low at start
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] adc_raw = 12'h000; // raw sample handed to the block
  logic adc_start;
  logic [4:0] adc_pos_sel;
  logic [4:0] adc_neg_sel;
  logic adc_diff;
  logic [3:0] adc_gain;
  logic result_ready;
  logic window_event;
  int errors = 0;
  int check_count = 0;
  int cycles = 0; // hang guard
  int starts = 0; // start pulses seen
  int res_n = 0; // result pulses seen
  int c0;
  int c1;
  logic [31:0] rd; // last read word
  logic err; // last error response
  logic [14:0] sel_s; // pos, neg, gain, diff latched at start
  logic win_s; // window event beside result ready
  // only defined gain codes are written; no internal input is selected
  logic [3:0] gtab [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
  logic [4:0] scan_exp [4] = '{5'h05, 5'h06, 5'h04, 5'h05};

  adcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_raw(adc_raw), .adc_start(adc_start), .adc_pos_sel(adc_pos_sel),
    .adc_neg_sel(adc_neg_sel), .adc_diff(adc_diff), .adc_gain(adc_gain),
    .result_ready(result_ready), .window_event(window_event));

  // =============================================================
  // clock, pulse counters and hang limit
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // limit covers the slow prescaler run with wide margin
  always @(posedge pclk) begin
    cycles++;
    if (adc_start === 1'b1) starts++;
    if (result_ready === 1'b1) res_n++;
    if (cycles == 60000) begin
      errors++;
      conclude();
    end
  end

  // =============================================================
  // bus and compare tasks
  // one transfer: setup, then access held until pready at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata; // taken at the completing edge only
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // wait for a start, latch selects, then time it to the result
  task automatic conv(output int cyc);
    int n;
    n = 0;
    cyc = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (adc_start !== 1'b1 && n < 9000);
    sel_s = {adc_pos_sel, adc_neg_sel, adc_gain, adc_diff};
    do begin
      @(posedge pclk);
      cyc++;
    end while (result_ready !== 1'b1 && cyc < 9000);
    win_s = window_event;
  endtask : conv

  // expected window hit for thresholds 0x80 and 0x200
  function automatic logic win_exp(input int m, input int r);
    case (m)
      1: return r > 128;
      2: return r < 512;
      3: return r > 128 && r < 512;
      4: return !(r > 128 && r < 512);
      default: return 1'b0; // off and reserved codes never hit
    endcase
  endfunction : win_exp

  // single place where the run ends
  task automatic conclude();
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // =============================================================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped place
    xfer(1'b0, `ADCC_OFF_WINDOW_CONTROL, 32'h0); chk(rd, 32'h0);
    xfer(1'b0, `ADCC_OFF_SOFTWARE_TRIGGER, 32'h0); chk(rd, 32'h0);
    xfer(1'b0, `ADCC_OFF_INCTRL, 32'h0); chk(rd, 32'h0);
    xfer(1'b0, 8'h40, 32'h0); chk({rd[30:0], err}, 32'h1);
    // slow ticks so repeated start writes land before the tick
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'h00000700);
    wr(`ADCC_OFF_INCTRL, 32'h02000504);
    adc_raw <= 12'hABC;
    starts = 0;
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h0);
    xfer(1'b0, `ADCC_OFF_SOFTWARE_TRIGGER, 32'h0); chk(rd, 32'h2);
    conv(c0);
    chk(sel_s, {5'h04, `ADCC_NEG_GND, 4'h2, 1'b0});
    xfer(1'b0, `ADCC_OFF_RESULT, 32'h0); chk(rd, 32'h0ABC);
    xfer(1'b0, `ADCC_OFF_SOFTWARE_TRIGGER, 32'h0); chk(rd, 32'h0);
    repeat (700) @(posedge pclk);
    chk(32'(starts), 32'h1);
    // left aligned differential conversion at fast ticks
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'h3);
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
    conv(c0);
    chk(sel_s, {5'h04, 5'h05, 4'h2, 1'b1});
    xfer(1'b0, `ADCC_OFF_RESULT, 32'h0); chk(rd, 32'hABC0);
    // correction: unity gain, offset two, two ticks longer
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'h0);
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
    conv(c0);
    wr(`ADCC_OFF_OFFCAL, 32'h2);
    wr(`ADCC_OFF_GAIN_CALIBRATION, 32'h800);
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'h8);
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
    conv(c1);
    xfer(1'b0, `ADCC_OFF_RESULT, 32'h0); chk(rd, 32'h0ABA);
    chk(32'(c1 - c0), 32'h8);
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'h0);
    // every window mode and reserved code 5, every gain code in gtab
    wr(`ADCC_OFF_WINDOW_LOWER_THRESHOLD, 32'h80);
    wr(`ADCC_OFF_WINDOW_UPPER_THRESHOLD, 32'h200);
    wr(`ADCC_OFF_EVCTRL, 32'h20);
    for (int i = 0; i < 12; i++) begin
      wr(`ADCC_OFF_WINDOW_CONTROL, 32'(i / 2));
      wr(`ADCC_OFF_INCTRL, {4'h0, gtab[i % 6], 24'h000504});
      adc_raw <= (i % 2 == 1) ? 12'h300 : 12'h100;
      wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
      conv(c0);
      chk({28'h0, sel_s[4:1]}, {28'h0, gtab[i % 6]});
      chk({31'h0, win_s}, {31'h0, win_exp(i / 2, 32'(adc_raw))});
    end
    // free running scan of three inputs from position one
    wr(`ADCC_OFF_INCTRL, 32'h00120004);
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'h4);
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
    for (int k = 0; k < 4; k++) begin
      conv(c0);
      chk({27'h0, sel_s[14:10]}, {27'h0, scan_exp[k]});
    end
    // stop, then flush the conversion in flight
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'h0);
    res_n = 0;
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h1);
    repeat (100) @(posedge pclk);
    chk(32'(res_n), 32'h0);
    xfer(1'b0, `ADCC_OFF_SOFTWARE_TRIGGER, 32'h0); chk(rd, 32'h0);
    // flush with a start pending still converts
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h3);
    conv(c0);
    chk(32'(c0 < 9000), 32'h1);
    xfer(1'b0, `ADCC_OFF_STATUS, 32'h0); chk({31'h0, rd[0]}, 32'h0);
    conclude();
  end
endmodule : adc_conversion_control_tb_top
